// ---- hw/line_regs_pkg.sv ----
// constants, types and carriers shared by the ring mode and line status bank
package line_regs_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] RING_DETECT_MODE_CTRL_OFS = 8'h12;
    localparam logic [7:0] LINE_FAULT_STATUS_OFS     = 8'h13;
    localparam logic [7:0] MONITOR_RX_GAIN_CTRL_OFS  = 8'h14;

    // ==========================================================
    // field positions
    localparam int FULL_WAVE_SEL_BIT      = 1;
    localparam int RX_OVERLOAD_LIVE_BIT   = 2;
    localparam int LINE_DROPOUT_BIT       = 1;
    localparam int LOOP_OVERCURRENT_BIT   = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] RING_DETECT_MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] MONITOR_RX_GAIN_CTRL_RST  = 8'h00;

    // ==========================================================
    // monitor gain scaling: unity code and shift for divide by 64
    localparam logic [7:0] MONITOR_GAIN_UNITY = 8'h40;
    localparam int         MONITOR_GAIN_SHIFT = 6;
    localparam int         RX_SAMPLE_W        = 16;
    localparam int         MONITOR_OUT_W      = 18;

    // ==========================================================
    // loop current thresholds in mA
    localparam logic [7:0] OVERCURRENT_LIMIT_HIGH_MA = 8'hA0;
    localparam logic [7:0] OVERCURRENT_LIMIT_LOW_MA  = 8'h3C;

    // ==========================================================
    // unqualified ring one-shot length in device clock cycles
    localparam logic [15:0] RING_ONESHOT_CYCLES = 16'h0400;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       ring_validation_enable;
        logic       ring_halfwave;
        logic       ring_fullwave;
        logic       ring_envelope;
        logic       ring_threshold_cross;
        logic       rx_level_excessive;
        logic       offhook_mask_active;
        logic       off_hook;
        logic       loop_current_flowing;
        logic       line_side_enabled;
        logic       current_limit_select;
        logic [7:0] loop_current_ma;
    } line_in_t;

    typedef struct packed {
        logic        active;
        logic [15:0] count;
    } oneshot_state_t;

    typedef struct packed {
        logic                            full_wave_ring_select;
        logic [7:0]                      monitor_gain;
        logic                            rx_overload_live;
        logic                            line_supply_dropout;
        logic                            loop_overcurrent_flag;
        logic                            rx_overload_sticky;
        logic                            rx_overload_irq_flag;
        logic                            ring_detect_output;
        logic [7:0]                      rdata;
        logic                            rvalid;
        logic signed [MONITOR_OUT_W-1:0] monitor_out;
    } bank_state_t;

endpackage

// ---- hw/ring_oneshot.sv ----
// non-retriggerable one-shot started by a ring threshold crossing
module ring_oneshot
    import line_regs_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic trigger,
    output logic      pulse
);

    oneshot_state_t state_reg;
    oneshot_state_t state_next;

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        if (state_reg.active) begin
            if (state_reg.count == RING_ONESHOT_CYCLES - 16'h0001) begin
                state_next.active = 1'b0;
                state_next.count  = 16'h0000;
            end else begin
                state_next.count = state_reg.count + 16'h0001;
            end
        end else if (trigger) begin
            state_next.active = 1'b1;
            state_next.count  = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign pulse = state_reg.active;

endmodule

// ---- hw/ring_mode_line_status_regs.sv ----
// ring detect mode, line fault status and monitor receive gain registers
// How it works
// R1: without ring validation, the full-wave select bit picks half-wave or full-wave ring output.
// R2: with validation and full-wave select clear, the ring output follows the validated envelope.
// R3: with validation and full-wave select set, the ring output is a threshold-started one-shot.
// R4: the live receive overload bit sets on excessive input and clears itself when it goes away.
// R5: the live overload bit is masked only by the off-hook counter, not by billing tone enable.
// R6: when off-hook, the dropout bit reads 1 if no loop current flows, else 0.
// R7: the dropout bit also reads 1 when on-hook while the line-side device is enabled.
// R8: the overcurrent bit sets at 160 mA with limit select 0 and at 60 mA with limit select 1.
// R9: the monitor receive signal is scaled by the gain code divided by 64.
// R10: a gain code of zero mutes the monitor receive signal entirely.
// R11: code 0xFF gives about +12 dB, 0x7F +6 dB, 0x20 -6 dB and 0x10 -12 dB.
// R12: the sticky overload bit holds until software clears it, clearing the overload irq flag too.
// R13: the one-shot length is a fixed count of device clock cycles.
// R14: reserved bits read zero and the status bits ignore writes.
module ring_mode_line_status_regs
    import line_regs_pkg::*;
(
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire logic                              clk_en,
    input  wire reg_req_t                          reg_req,
    output logic [7:0]                             reg_rdata,
    output logic                                   reg_rvalid,
    input  wire line_in_t                          line_in,
    input  wire logic                              sticky_clear,
    input  wire logic                              rx_sample_valid,
    input  wire logic signed [RX_SAMPLE_W-1:0]     rx_sample,
    output logic                                   ring_detect_output,
    output logic                                   rx_overload_sticky,
    output logic                                   rx_overload_irq_flag,
    output logic signed [MONITOR_OUT_W-1:0]        call_progress_output
);

    bank_state_t state_reg;
    bank_state_t state_next;
    logic        oneshot_pulse;
    logic        overload_now;
    logic        overcurrent_now;
    logic        dropout_now;
    logic        ring_sel;

    // ==========================================================
    // helpers
    function automatic logic [7:0] current_limit(input logic limit_select);
        current_limit = limit_select ? OVERCURRENT_LIMIT_LOW_MA : OVERCURRENT_LIMIT_HIGH_MA;
    endfunction

    function automatic logic signed [MONITOR_OUT_W-1:0] scale_monitor(
        input logic signed [RX_SAMPLE_W-1:0] sample,
        input logic [7:0]                    gain
    );
        logic signed [RX_SAMPLE_W+8:0] product;
        product = sample * $signed({1'b0, gain});
        scale_monitor = MONITOR_OUT_W'(product >>> MONITOR_GAIN_SHIFT);
    endfunction

    function automatic logic [7:0] read_word(input bank_state_t s, input logic [7:0] addr);
        logic [7:0] word;
        word = 8'h00;
        if (addr == RING_DETECT_MODE_CTRL_OFS) begin
            word[FULL_WAVE_SEL_BIT] = s.full_wave_ring_select;
        end else if (addr == LINE_FAULT_STATUS_OFS) begin
            word[RX_OVERLOAD_LIVE_BIT] = s.rx_overload_live;
            word[LINE_DROPOUT_BIT]     = s.line_supply_dropout;
            word[LOOP_OVERCURRENT_BIT] = s.loop_overcurrent_flag;
        end else if (addr == MONITOR_RX_GAIN_CTRL_OFS) begin
            word = s.monitor_gain;
        end
        read_word = word;
    endfunction

    // ==========================================================
    // unqualified ring one-shot
    // R13: fixed cycle length
    ring_oneshot i_ring_oneshot (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .trigger (line_in.ring_threshold_cross),
        .pulse   (oneshot_pulse)
    );

    // ==========================================================
    // live line conditions
    // R4: overload follows input
    // R5: off-hook counter mask only
    assign overload_now = line_in.rx_level_excessive & ~line_in.offhook_mask_active;
    // R8: threshold by limit select
    assign overcurrent_now = line_in.loop_current_ma >= current_limit(line_in.current_limit_select);
    // R6: no loop current off-hook
    // R7: on-hook with line side enabled
    assign dropout_now = line_in.off_hook ? ~line_in.loop_current_flowing
                                          : line_in.line_side_enabled;

    // ==========================================================
    // ring detect output selection
    always_comb begin
        ring_sel = 1'b0;
        case ({line_in.ring_validation_enable, state_reg.full_wave_ring_select})
            // R1: half-wave or full-wave
            2'b00:   ring_sel = line_in.ring_halfwave;
            2'b01:   ring_sel = line_in.ring_fullwave;
            // R2: validated envelope
            2'b10:   ring_sel = line_in.ring_envelope;
            // R3: threshold one-shot
            default: ring_sel = oneshot_pulse;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        state_next        = state_reg;
        state_next.rvalid = 1'b0;
        if (reg_req.wr) begin
            // R14: only the select bit of the ring mode register is kept, the gain register keeps all bits
            if (reg_req.addr == RING_DETECT_MODE_CTRL_OFS) begin
                state_next.full_wave_ring_select = reg_req.wdata[FULL_WAVE_SEL_BIT];
            end else if (reg_req.addr == MONITOR_RX_GAIN_CTRL_OFS) begin
                state_next.monitor_gain = reg_req.wdata;
            end
        end
        if (reg_req.rd) begin
            state_next.rdata  = read_word(state_reg, reg_req.addr);
            state_next.rvalid = 1'b1;
        end
        state_next.rx_overload_live      = overload_now;
        state_next.line_supply_dropout   = dropout_now;
        state_next.loop_overcurrent_flag = overcurrent_now;
        // R12: set wins over software clear
        if (overload_now) begin
            state_next.rx_overload_sticky   = 1'b1;
            state_next.rx_overload_irq_flag = 1'b1;
        end else if (sticky_clear) begin
            state_next.rx_overload_sticky   = 1'b0;
            state_next.rx_overload_irq_flag = 1'b0;
        end
        state_next.ring_detect_output = ring_sel;
        if (rx_sample_valid) begin
            // R10: zero code mutes
            if (state_reg.monitor_gain == 8'h00) begin
                state_next.monitor_out = '0;
            end else begin
                // R9: gain code over 64
                // R11: linear code reference points
                state_next.monitor_out = scale_monitor(rx_sample, state_reg.monitor_gain);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg              <= '0;
            state_reg.full_wave_ring_select <= RING_DETECT_MODE_CTRL_RST[FULL_WAVE_SEL_BIT];
            state_reg.monitor_gain <= MONITOR_RX_GAIN_CTRL_RST;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata            = state_reg.rdata;
    assign reg_rvalid           = state_reg.rvalid;
    assign ring_detect_output   = state_reg.ring_detect_output;
    assign rx_overload_sticky   = state_reg.rx_overload_sticky;
    assign rx_overload_irq_flag = state_reg.rx_overload_irq_flag;
    assign call_progress_output = state_reg.monitor_out;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_halfwave_mode;
        clk_en && !line_in.ring_validation_enable && !state_reg.full_wave_ring_select
            |=> ring_detect_output == $past(line_in.ring_halfwave);
    endproperty
    a_halfwave_mode: assert property (p_halfwave_mode) // R1
        else $error("ring output does not follow half-wave detector");

    property p_envelope_mode;
        clk_en && line_in.ring_validation_enable && !state_reg.full_wave_ring_select
            |=> ring_detect_output == $past(line_in.ring_envelope);
    endproperty
    a_envelope_mode: assert property (p_envelope_mode) // R2
        else $error("ring output does not follow validated envelope");

    property p_oneshot_mode;
        clk_en && line_in.ring_validation_enable && state_reg.full_wave_ring_select
            |=> ring_detect_output == $past(oneshot_pulse);
    endproperty
    a_oneshot_mode: assert property (p_oneshot_mode) // R3
        else $error("ring output does not follow one-shot");

    property p_overload_live;
        clk_en |=> state_reg.rx_overload_live
                   == $past(line_in.rx_level_excessive && !line_in.offhook_mask_active);
    endproperty
    a_overload_live: assert property (p_overload_live) // R4
        else $error("live overload bit wrong");

    property p_dropout;
        clk_en |=> state_reg.line_supply_dropout
                   == ($past(line_in.off_hook) ? !$past(line_in.loop_current_flowing)
                                               : $past(line_in.line_side_enabled));
    endproperty
    a_dropout: assert property (p_dropout) // R6
        else $error("dropout bit wrong");

    property p_overcurrent;
        clk_en |=> state_reg.loop_overcurrent_flag
                   == ($past(line_in.loop_current_ma)
                       >= ($past(line_in.current_limit_select) ? 8'h3C : 8'hA0));
    endproperty
    a_overcurrent: assert property (p_overcurrent) // R8
        else $error("overcurrent threshold wrong");

    property p_mute;
        clk_en && rx_sample_valid && state_reg.monitor_gain == 8'h00
            |=> call_progress_output == 0;
    endproperty
    a_mute: assert property (p_mute) // R10
        else $error("monitor not muted at zero gain");

    property p_unity;
        clk_en && rx_sample_valid && state_reg.monitor_gain == 8'h40
            |=> call_progress_output == $past(rx_sample);
    endproperty
    a_unity: assert property (p_unity) // R9
        else $error("unity gain code does not pass sample");

    property p_sticky_hold;
        state_reg.rx_overload_sticky && !sticky_clear |=> rx_overload_sticky;
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) // R12
        else $error("sticky overload dropped without clear");

    property p_reserved_read_zero;
        clk_en && reg_req.rd && reg_req.addr != MONITOR_RX_GAIN_CTRL_OFS
            |=> (reg_rdata & (($past(reg_req.addr) == LINE_FAULT_STATUS_OFS) ? 8'hF8 : 8'hFD))
                == 8'h00;
    endproperty
    a_reserved_read_zero: assert property (p_reserved_read_zero) // R14
        else $error("reserved read bits not zero");

    property p_oneshot_start;
        $rose(oneshot_pulse) |-> $past(line_in.ring_threshold_cross);
    endproperty
    a_oneshot_start: assert property (p_oneshot_start) // R3
        else $error("one-shot started without a threshold crossing");

    property p_sticky_set;
        clk_en && overload_now
            |=> rx_overload_sticky && rx_overload_irq_flag;
    endproperty
    a_sticky_set: assert property (p_sticky_set) // R12
        else $error("sticky overload or irq flag not set by overload");

    property p_sticky_clear;
        clk_en && sticky_clear && !overload_now
            |=> !rx_overload_sticky && !rx_overload_irq_flag;
    endproperty
    a_sticky_clear: assert property (p_sticky_clear) // R12
        else $error("sticky overload or irq flag not cleared");

    property p_select_write;
        clk_en && reg_req.wr && reg_req.addr == RING_DETECT_MODE_CTRL_OFS
            |=> state_reg.full_wave_ring_select == $past(reg_req.wdata[FULL_WAVE_SEL_BIT]);
    endproperty
    a_select_write: assert property (p_select_write) // R1
        else $error("full-wave select write not taken");

    property p_gain_write;
        clk_en && reg_req.wr && reg_req.addr == MONITOR_RX_GAIN_CTRL_OFS
            |=> state_reg.monitor_gain == $past(reg_req.wdata);
    endproperty
    a_gain_write: assert property (p_gain_write) // R9
        else $error("monitor gain write not taken");

    property p_gain_readback;
        clk_en && reg_req.rd && reg_req.addr == MONITOR_RX_GAIN_CTRL_OFS
            |=> reg_rvalid && reg_rdata == $past(state_reg.monitor_gain);
    endproperty
    a_gain_readback: assert property (p_gain_readback) // R9
        else $error("monitor gain read back wrong");

    property p_double_gain;
        clk_en && rx_sample_valid && state_reg.monitor_gain == 8'h80
            |=> call_progress_output == $past(rx_sample) * 2;
    endproperty
    a_double_gain: assert property (p_double_gain) // R11
        else $error("double gain code does not double sample");

    property p_dropout_onhook;
        clk_en && !line_in.off_hook && line_in.line_side_enabled
            |=> state_reg.line_supply_dropout;
    endproperty
    a_dropout_onhook: assert property (p_dropout_onhook) // R7
        else $error("dropout bit clear on-hook with line side enabled");

    property p_overload_mask;
        clk_en && line_in.offhook_mask_active |=> !state_reg.rx_overload_live;
    endproperty
    a_overload_mask: assert property (p_overload_mask) // R5
        else $error("live overload bit not masked");

endmodule

// ---- dv/line_side_model.sv ----
// behavioural line-side device driving the bank's line inputs
module line_side_model
    import line_regs_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire line_in_t cmd,
    output line_in_t      line_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic cross_d = 1'b0;

    initial line_in = '0;

    // ==========================================================
    // line outputs, one cycle behind the command
    always @(posedge sys_clk) begin
        cross_d <= cmd.ring_threshold_cross;
        line_in <= cmd;
        // a crossing is a single-cycle event
        line_in.ring_threshold_cross <= cmd.ring_threshold_cross & ~cross_d;
        // no loop current can flow while on-hook
        line_in.loop_current_flowing <= cmd.loop_current_flowing & cmd.off_hook;
        line_in.loop_current_ma <= cmd.off_hook ? cmd.loop_current_ma : 8'h00;
    end
endmodule

// ---- dv/ring_mode_line_status_regs_tb.sv ----
// self-checking bench for the ring mode and line status register bank
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end

module ring_mode_line_status_regs_tb
    import line_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                            sys_clk = 1'b0;
    logic                            rst = 1'b1;
    logic                            clk_en = 1'b1;
    logic                            sticky_clear = 1'b0;
    logic                            rx_sample_valid = 1'b0;
    logic signed [RX_SAMPLE_W-1:0]   rx_sample = '0;
    reg_req_t                        reg_req = '0;
    line_in_t                        cmd = '0;
    line_in_t                        line_in;
    logic [7:0]                      reg_rdata;
    logic                            reg_rvalid;
    logic                            ring_detect_output;
    logic                            rx_overload_sticky;
    logic                            rx_overload_irq_flag;
    logic signed [MONITOR_OUT_W-1:0] call_progress_output;
    int                              miscompares = 0;
    int                              n_compared = 0;
    int                              cycles = 0;
    logic [7:0]                      rd_q[$];
    logic [MONITOR_OUT_W-1:0]        mon_q[$];
    logic                            mon_due = 1'b0;
    logic [7:0]                      er;
    logic [MONITOR_OUT_W-1:0]        em;
    logic [31:0]                     r;
    logic [7:0]                      lims[5] = '{8'h3B, 8'h3C, 8'h9F, 8'hA0, 8'hFF};
    logic [7:0]                      codes[7] = '{8'h00, 8'hFF, 8'h7F, 8'h40, 8'h80, 8'h20, 8'h10};

    always #2 sys_clk = ~sys_clk;

    ring_mode_line_status_regs i_ring_mode_line_status_regs (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .line_in(line_in),
        .sticky_clear(sticky_clear), .rx_sample_valid(rx_sample_valid),
        .rx_sample(rx_sample), .ring_detect_output(ring_detect_output),
        .rx_overload_sticky(rx_overload_sticky),
        .rx_overload_irq_flag(rx_overload_irq_flag),
        .call_progress_output(call_progress_output)
    );

    line_side_model i_line_side_model (.sys_clk(sys_clk), .cmd(cmd), .line_in(line_in));

    // ==========================================================
    // drivers
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick(1);
        reg_req = '0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        rd_q.push_back(e);
        tick(1);
        reg_req = '0;
    endtask

    task automatic mon(input logic [7:0] g, input logic signed [15:0] s);
        logic signed [25:0] p;
        p = s * $signed({1'b0, g});
        tick(1);
        rx_sample = s;
        rx_sample_valid = 1'b1;
        mon_q.push_back(g == 8'h00 ? '0 : p[23:6]);
        tick(1);
        rx_sample_valid = 1'b0;
    endtask

    function automatic logic [7:0] status_exp();
        logic [7:0] lim;
        lim = line_in.current_limit_select ? OVERCURRENT_LIMIT_LOW_MA : OVERCURRENT_LIMIT_HIGH_MA;
        return {5'h00, line_in.rx_level_excessive & ~line_in.offhook_mask_active,
                line_in.off_hook ? ~line_in.loop_current_flowing : line_in.line_side_enabled,
                line_in.loop_current_ma >= lim};
    endfunction

    // ==========================================================
    // watcher: oldest note against each result
    always @(posedge sys_clk) mon_due <= rx_sample_valid;

    always @(negedge sys_clk) begin
        if (reg_rvalid === 1'b1 && rd_q.size() > 0) begin
            er = rd_q.pop_front();
            `CHK(reg_rdata, er)
        end
        if (mon_due && mon_q.size() > 0) begin
            em = mon_q.pop_front();
            `CHK(call_progress_output, em)
        end
    end

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hE8D9));
        tick(3);
        rst = 1'b0;
        bus_rd(8'h12, 8'h00);
        bus_rd(8'h14, 8'h00);
        bus_rd(8'h15, 8'h00);
        bus_wr(8'h12, 8'hFF);
        bus_rd(8'h12, 8'h02);
        bus_wr(8'h13, 8'hFF);
        bus_rd(8'h13, status_exp());
        cmd.rx_level_excessive = 1'b1;
        cmd.offhook_mask_active = 1'b1;
        tick(4);
        `CHK(rx_overload_sticky, 1'b0)
        bus_rd(8'h13, 8'h00);
        cmd.offhook_mask_active = 1'b0;
        tick(4);
        `CHK(rx_overload_sticky, 1'b1)
        `CHK(rx_overload_irq_flag, 1'b1)
        bus_rd(8'h13, status_exp());
        cmd.rx_level_excessive = 1'b0;
        tick(4);
        bus_rd(8'h13, status_exp());
        `CHK(rx_overload_sticky, 1'b1)
        sticky_clear = 1'b1;
        tick(1);
        sticky_clear = 1'b0;
        tick(2);
        `CHK(rx_overload_sticky, 1'b0)
        `CHK(rx_overload_irq_flag, 1'b0)
        // set wins over a clear in the same cycle
        cmd.rx_level_excessive = 1'b1;
        tick(3);
        sticky_clear = 1'b1;
        tick(1);
        sticky_clear = 1'b0;
        `CHK(rx_overload_sticky, 1'b1)
        for (int i = 0; i < 40; i++) begin
            r = $urandom;
            cmd = r[$bits(line_in_t)-1:0];
            cmd.ring_threshold_cross = 1'b0;
            cmd.current_limit_select = i[0];
            if (i < 10) cmd.off_hook = 1'b1;
            cmd.loop_current_ma = i < 10 ? lims[i % 5] : r[31:24];
            tick(3);
            bus_rd(8'h13, status_exp());
        end
        foreach (codes[i]) begin
            bus_wr(8'h14, codes[i]);
            bus_rd(8'h14, codes[i]);
            for (int j = 0; j < 5; j++) mon(codes[i], j == 0 ? 16'sh8000 : 16'($urandom));
        end
        for (int m = 0; m < 32; m++) begin
            bus_wr(8'h12, {6'h00, m[0], 1'b0});
            cmd = '0;
            cmd.ring_validation_enable = m[1];
            cmd.ring_halfwave = m[2];
            cmd.ring_fullwave = m[3];
            cmd.ring_envelope = m[4];
            tick(3);
            `CHK(ring_detect_output, m[1] ? (m[0] ? 1'b0 : m[4]) : (m[0] ? m[3] : m[2]))
        end
        bus_wr(8'h12, 8'h02);
        cmd = '0;
        cmd.ring_validation_enable = 1'b1;
        tick(3);
        cmd.ring_threshold_cross = 1'b1;
        tick(20);
        `CHK(ring_detect_output, 1'b1)
        cmd.ring_threshold_cross = 1'b0;
        tick(480);
        cmd.ring_threshold_cross = 1'b1;
        tick(500);
        `CHK(ring_detect_output, 1'b1)
        // output falls 1024 cycles after the first one-shot cycle
        tick(26);
        `CHK(ring_detect_output, 1'b1)
        tick(1);
        `CHK(ring_detect_output, 1'b0)
        // write ignored while clock enable is low
        clk_en = 1'b0;
        bus_wr(8'h14, 8'h55);
        clk_en = 1'b1;
        bus_rd(8'h14, 8'h10);
        // second reset in mid-run
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        `CHK(rx_overload_sticky, 1'b0)
        bus_rd(8'h14, 8'h00);
        bus_rd(8'h12, 8'h00);
        tick(5);
        `CHK(rd_q.size() + mon_q.size(), 0)
        give_verdict();
    end
endmodule
